// [verilog/pin_mux_pkg.sv]
`default_nettype none
package pin_mux_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned ST_W   = 9;
  localparam int unsigned ALT_W  = 5;

  localparam logic [ADDR_W-1:0] A_DATA_A = 8'h00;
  localparam logic [ADDR_W-1:0] A_DATA_B = 8'h04;
  localparam logic [ADDR_W-1:0] A_DATA_C = 8'h08;
  localparam logic [ADDR_W-1:0] A_DIR_A  = 8'h0c;
  localparam logic [ADDR_W-1:0] A_DIR_B  = 8'h10;
  localparam logic [ADDR_W-1:0] A_DIR_C  = 8'h14;
  localparam logic [ADDR_W-1:0] A_ALT    = 8'h18;
  localparam logic [ADDR_W-1:0] A_OPTION = 8'h1c;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] A_MASK   = 8'h24;

  // Alternate function select bits
  localparam int unsigned ALT_SPI  = 0;
  localparam int unsigned ALT_AN3  = 1;
  localparam int unsigned ALT_AN4  = 2;
  localparam int unsigned ALT_CAP1 = 3;
  localparam int unsigned ALT_CAP2 = 4;

  // Option register: edge-only sensitivity of the main pin
  localparam int unsigned OPT_EDGE = 0;
  localparam logic        OPT_RST  = 1'b0;

  // Status and mask layout
  localparam int unsigned ST_MAIN = 0;
  localparam int unsigned ST_X1   = 1;
  localparam int unsigned ST_X2   = 2;
  localparam int unsigned ST_X3   = 3;
  localparam int unsigned ST_KB   = 4;
  localparam int unsigned KB_N    = 5;

  // Port A line roles
  localparam int unsigned LA_X1 = 0;
  localparam int unsigned LA_X2 = 1;
  localparam int unsigned LA_X3 = 2;
  localparam int unsigned LA_KB = 3;

  // Port C line roles
  localparam int unsigned PC_SPI  = 0;
  localparam int unsigned SPI_N   = 4;
  localparam int unsigned PC_AN3  = 4;
  localparam int unsigned PC_AN4  = 5;
  localparam int unsigned PC_CAP1 = 6;
  localparam int unsigned PC_CAP2 = 7;

  localparam logic [PORT_W-1:0] DIR_RST  = 8'h00;
  localparam logic [PORT_W-1:0] DATA_RST = 8'h00;
  localparam logic [SPI_N-1:0]  SPI_IDLE = 4'h8;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } pins_s;

  typedef struct packed {
    logic [SPI_N-1:0] out;
    logic [SPI_N-1:0] oe;
  } spi_pins_s;
endpackage
`default_nettype wire

// [verilog/pin_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
  parameter int unsigned W = 25
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // Stage one is read only by stage two
  always_comb begin
    next_r    = r;
    next_r.s1 = pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{default: '1};
    end else begin
      r <= next_r;
    end
  end

  assign lvl  = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule
`default_nettype wire

// [verilog/port_pin_sharing_and_ext_irq.sv]
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - All port lines reset to input
// - Serial clock on port C line zero
// - Serial data pins become port C one, two
// - Slave select becomes port C three
// - Only third, fourth analog inputs reassignable
// - First capture from pin, else line six
// - Second capture from pin, else line seven
// - First, second extra interrupts: falling edge only
// - Third extra interrupt: both edges
// - Extra and keyboard interrupts share port A
// - Main pin has two sensitivities by option
// - Option one: falling edge; zero: level too
// - Option register written once after reset
module port_pin_sharing_and_ext_irq
  import pin_mux_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic [PORT_W-1:0] port_a_lines_in,
  output logic      [PORT_W-1:0] port_a_lines_out,
  output logic      [PORT_W-1:0] port_a_lines_oe,
  input  wire logic [PORT_W-1:0] port_b_lines_in,
  output logic      [PORT_W-1:0] port_b_lines_out,
  output logic      [PORT_W-1:0] port_b_lines_oe,
  input  wire logic [PORT_W-1:0] port_c_lines_in,
  output logic      [PORT_W-1:0] port_c_lines_out,
  output logic      [PORT_W-1:0] port_c_lines_oe,
  input  wire logic              main_irq_pin_n,
  input  wire spi_pins_s         spi_pins,
  output logic      [SPI_N-1:0]  spi_pin_in,
  output logic                   capture_input_first,
  output logic                   capture_input_second
);
  localparam int unsigned SW = 3 * PORT_W + 1;

  typedef struct packed {
    logic [PORT_W-1:0] data_a;
    logic [PORT_W-1:0] data_b;
    logic [PORT_W-1:0] data_c;
    logic [PORT_W-1:0] dir_a;
    logic [PORT_W-1:0] dir_b;
    logic [PORT_W-1:0] dir_c;
    logic [ALT_W-1:0]  alt;
    logic              opt_edge;
    logic              opt_locked;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    pins_s             pa;
    pins_s             pb;
    pins_s             pc;
    logic [SPI_N-1:0]  spi_in;
    logic              cap1;
    logic              cap2;
  } state_s;

  state_s r;
  state_s next_r;

  logic [SW-1:0]     s_lvl;
  logic [SW-1:0]     s_rise;
  logic [SW-1:0]     s_fall;
  logic [PORT_W-1:0] a_lvl;
  logic [PORT_W-1:0] b_lvl;
  logic [PORT_W-1:0] c_lvl;
  logic [PORT_W-1:0] a_rise;
  logic [PORT_W-1:0] a_fall;
  logic              main_lvl;
  logic              main_fall;

  // All pins, main pin included, cross in through two flops
  pin_sync_edge #(
    .W (SW)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     ({main_irq_pin_n, port_c_lines_in,
               port_b_lines_in, port_a_lines_in}),
    .lvl     (s_lvl),
    .rise    (s_rise),
    .fall    (s_fall)
  );

  assign a_lvl     = s_lvl[PORT_W-1:0];
  assign b_lvl     = s_lvl[2*PORT_W-1:PORT_W];
  assign c_lvl     = s_lvl[3*PORT_W-1:2*PORT_W];
  assign a_rise    = s_rise[PORT_W-1:0];
  assign a_fall    = s_fall[PORT_W-1:0];
  assign main_lvl  = s_lvl[SW-1];
  assign main_fall = s_fall[SW-1];

  logic              setup;
  logic              wr;
  logic [ST_W-1:0]   ev;
  logic [ST_W-1:0]   clr;
  logic [PORT_W-1:0] rd_a;
  logic [PORT_W-1:0] rd_b;
  logic [PORT_W-1:0] rd_c;

  always_comb begin
    next_r = r;
    setup  = psel & ~penable;
    // Write lands only on the access edge the slave answers
    wr     = psel & penable & r.pready & pwrite;
    clr    = '0;
    ev     = '0;
    // Inputs read the pin, outputs read back the latch
    rd_a   = (r.dir_a & r.data_a) | (~r.dir_a & a_lvl);
    rd_b   = (r.dir_b & r.data_b) | (~r.dir_b & b_lvl);
    rd_c   = (r.dir_c & r.data_c) | (~r.dir_c & c_lvl);

    // Interrupt sources on port A lines
    ev[ST_X1] = a_fall[LA_X1];
    ev[ST_X2] = a_fall[LA_X2];
    ev[ST_X3] = a_fall[LA_X3] | a_rise[LA_X3];
    ev[ST_KB +: KB_N] = a_fall[LA_KB +: KB_N];
    // Level mode keeps re-setting while the pin stays low
    if (r.opt_edge) begin
      ev[ST_MAIN] = main_fall;
    end else begin
      ev[ST_MAIN] = main_fall | ~main_lvl;
    end

    // Register bus, zero wait states
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      unique case (paddr)
        A_DATA_A: next_r.prdata[PORT_W-1:0] = rd_a;
        A_DATA_B: next_r.prdata[PORT_W-1:0] = rd_b;
        A_DATA_C: next_r.prdata[PORT_W-1:0] = rd_c;
        A_DIR_A:  next_r.prdata[PORT_W-1:0] = r.dir_a;
        A_DIR_B:  next_r.prdata[PORT_W-1:0] = r.dir_b;
        A_DIR_C:  next_r.prdata[PORT_W-1:0] = r.dir_c;
        A_ALT:    next_r.prdata[ALT_W-1:0]  = r.alt;
        A_OPTION: next_r.prdata[OPT_EDGE]   = r.opt_edge;
        A_STATUS: next_r.prdata[ST_W-1:0]   = r.status;
        A_MASK:   next_r.prdata[ST_W-1:0]   = r.mask;
        default:  next_r.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        A_DATA_A: next_r.data_a = pwdata[PORT_W-1:0];
        A_DATA_B: next_r.data_b = pwdata[PORT_W-1:0];
        A_DATA_C: next_r.data_c = pwdata[PORT_W-1:0];
        A_DIR_A:  next_r.dir_a  = pwdata[PORT_W-1:0];
        A_DIR_B:  next_r.dir_b  = pwdata[PORT_W-1:0];
        A_DIR_C:  next_r.dir_c  = pwdata[PORT_W-1:0];
        A_ALT:    next_r.alt    = pwdata[ALT_W-1:0];
        A_OPTION: begin
          // Later writes are dropped silently, no error
          if (!r.opt_locked) begin
            next_r.opt_edge   = pwdata[OPT_EDGE];
            next_r.opt_locked = 1'b1;
          end
        end
        A_STATUS: clr         = pwdata[ST_W-1:0];
        A_MASK:   next_r.mask = pwdata[ST_W-1:0];
        default:  ;
      endcase
    end
    // New event wins over a same-cycle clear
    next_r.status = (r.status & ~clr) | ev;
    next_r.irq    = |(next_r.status & next_r.mask);

    // Pin drive, plain port use first
    next_r.pa.out = r.data_a;
    next_r.pa.oe  = r.dir_a;
    next_r.pb.out = r.data_b;
    next_r.pb.oe  = r.dir_b;
    next_r.pc.out = r.data_c;
    next_r.pc.oe  = r.dir_c;
    // Serial unit owns the four low lines as one group
    if (r.alt[ALT_SPI]) begin
      next_r.pc.out[PC_SPI +: SPI_N] = spi_pins.out;
      next_r.pc.oe[PC_SPI +: SPI_N]  = spi_pins.oe;
      next_r.spi_in = c_lvl[PC_SPI +: SPI_N];
    end else begin
      next_r.spi_in = SPI_IDLE;
    end
    // Converter and capture inputs: digital driver kept off the pin
    if (r.alt[ALT_AN3]) begin
      next_r.pc.out[PC_AN3] = 1'b0;
      next_r.pc.oe[PC_AN3]  = 1'b0;
    end
    if (r.alt[ALT_AN4]) begin
      next_r.pc.out[PC_AN4] = 1'b0;
      next_r.pc.oe[PC_AN4]  = 1'b0;
    end
    if (r.alt[ALT_CAP1]) begin
      next_r.pc.out[PC_CAP1] = 1'b0;
      next_r.pc.oe[PC_CAP1]  = 1'b0;
    end
    if (r.alt[ALT_CAP2]) begin
      next_r.pc.out[PC_CAP2] = 1'b0;
      next_r.pc.oe[PC_CAP2]  = 1'b0;
    end
    next_r.cap1 = r.alt[ALT_CAP1] & c_lvl[PC_CAP1];
    next_r.cap2 = r.alt[ALT_CAP2] & c_lvl[PC_CAP2];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r            <= '0;
      r.data_a     <= DATA_RST;
      r.data_b     <= DATA_RST;
      r.data_c     <= DATA_RST;
      r.dir_a      <= DIR_RST;
      r.dir_b      <= DIR_RST;
      r.dir_c      <= DIR_RST;
      r.opt_edge   <= OPT_RST;
      r.spi_in     <= SPI_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata               = r.prdata;
  assign pready               = r.pready;
  assign pslverr              = r.pslverr;
  assign irq                  = r.irq;
  assign port_a_lines_out     = r.pa.out;
  assign port_a_lines_oe      = r.pa.oe;
  assign port_b_lines_out     = r.pb.out;
  assign port_b_lines_oe      = r.pb.oe;
  assign port_c_lines_out     = r.pc.out;
  assign port_c_lines_oe      = r.pc.oe;
  assign spi_pin_in           = r.spi_in;
  assign capture_input_first  = r.cap1;
  assign capture_input_second = r.cap2;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_DIR_RESET:
    assert property ($past(sys_rst) |->
      (r.dir_a | r.dir_b | r.dir_c) == '0)
    else $error("port direction not input after reset");

  AST_SCK_ROUTE:
    assert property (r.alt[ALT_SPI] |=>
      port_c_lines_out[PC_SPI] == $past(spi_pins.out[0]) &&
      port_c_lines_oe[PC_SPI] == $past(spi_pins.oe[0]))
    else $error("serial clock not routed to line zero");

  AST_DATA_PORT:
    assert property (!r.alt[ALT_SPI] |=>
      port_c_lines_oe[2:1] == $past(r.dir_c[2:1]) &&
      spi_pin_in == SPI_IDLE)
    else $error("data pins not plain port lines");

  AST_SS_ROUTE:
    assert property (r.alt[ALT_SPI] |=>
      spi_pin_in[SPI_N-1] == $past(c_lvl[PC_SPI+SPI_N-1]))
    else $error("slave select not fed from pin");

  AST_AN_OFF:
    assert property (r.alt[ALT_AN3] && r.alt[ALT_AN4] |=>
      port_c_lines_oe[PC_AN4:PC_AN3] == 2'h0)
    else $error("analog pin still driven");

  AST_CAP1:
    assert property (r.alt[ALT_CAP1] |=>
      capture_input_first == $past(c_lvl[PC_CAP1]) &&
      !port_c_lines_oe[PC_CAP1])
    else $error("first capture not from pin");

  AST_CAP2:
    assert property (!r.alt[ALT_CAP2] |=>
      !capture_input_second &&
      port_c_lines_oe[PC_CAP2] == $past(r.dir_c[PC_CAP2]))
    else $error("line seven not a port bit");

  AST_X1_FALL:
    assert property ($rose(r.status[ST_X1]) |->
      $past(a_fall[LA_X1]))
    else $error("extra interrupt one set without fall");

  AST_X2_FALL:
    assert property ($rose(r.status[ST_X2]) |->
      $past(a_fall[LA_X2]))
    else $error("extra interrupt two set without fall");

  AST_KB_FALL:
    assert property ((r.status[ST_KB +: KB_N] &
      ~$past(r.status[ST_KB +: KB_N]) &
      ~$past(a_fall[LA_KB +: KB_N])) == '0)
    else $error("keyboard status set without falling edge");

  AST_X3_BOTH:
    assert property (a_rise[LA_X3] || a_fall[LA_X3] |=>
      r.status[ST_X3])
    else $error("extra interrupt three missed edge");

  AST_MAIN_LEVEL:
    assert property (!r.opt_edge && !main_lvl |=>
      r.status[ST_MAIN] && (irq || !r.mask[ST_MAIN]))
    else $error("main pin level not seen");

  AST_MAIN_EDGE:
    assert property ($rose(r.status[ST_MAIN]) &&
      $past(r.opt_edge) |-> $past(main_fall))
    else $error("edge mode set without falling edge");

  AST_OPT_ONCE:
    assert property (r.opt_locked |=> $stable(r.opt_edge))
    else $error("option changed after first write");

  AST_PORT_BIT:
    assert property (!r.alt[ALT_SPI] |=>
      port_c_lines_out[PC_SPI] == $past(r.data_c[PC_SPI]))
    else $error("line zero not driven from latch");

  AST_EDGE_NO_LEVEL:
    assert property (r.opt_edge && !main_fall && !r.status[ST_MAIN] |=>
      !r.status[ST_MAIN])
    else $error("edge mode set on a steady level");

  AST_PA_PORT:
    assert property (port_a_lines_oe == $past(r.dir_a) &&
      port_a_lines_out == $past(r.data_a))
    else $error("port A lines not plain port bits");
endmodule
`default_nettype wire

// [bench/board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module board_model
  import pin_mux_pkg::*;
(
  input  wire logic [3*PORT_W-1:0] dev_out,
  input  wire logic [3*PORT_W-1:0] dev_oe,
  input  wire logic [3*PORT_W-1:0] board_lvl,
  output logic      [3*PORT_W-1:0] pin_lvl
);
  // Device drive wins; elsewhere the board drivers set the level,
  // so a released line never keeps a stale value
  assign pin_lvl = (dev_oe & dev_out) | (~dev_oe & board_lvl);
endmodule
`default_nettype wire

// [bench/port_pin_sharing_and_ext_irq_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module port_pin_sharing_and_ext_irq_tb_top
  import pin_mux_pkg::*;
  ;
  logic              clk, sys_rst, psel, penable, pwrite, main_irq_pin_n;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic              pready, pslverr, irq, err, cap1, cap2;
  logic [PORT_W-1:0] a_out, a_oe, b_out, b_oe, c_out, c_oe;
  logic [PORT_W-1:0] brd_a, brd_b, brd_c, d, m;
  wire  [PORT_W-1:0] a_in, b_in, c_in;
  logic [ST_W-1:0]   msk;
  logic [SPI_N-1:0]  spi_in;
  spi_pins_s         spi_pins;
  int                num_errors = 0, num_checks = 0, cyc = 0;

  port_pin_sharing_and_ext_irq i_port_pin_sharing_and_ext_irq (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_a_lines_in(a_in), .port_a_lines_out(a_out),
    .port_a_lines_oe(a_oe), .port_b_lines_in(b_in),
    .port_b_lines_out(b_out), .port_b_lines_oe(b_oe),
    .port_c_lines_in(c_in), .port_c_lines_out(c_out),
    .port_c_lines_oe(c_oe), .main_irq_pin_n(main_irq_pin_n),
    .spi_pins(spi_pins), .spi_pin_in(spi_in),
    .capture_input_first(cap1), .capture_input_second(cap2));

  board_model i_board_model (
    .dev_out({c_out, b_out, a_out}), .dev_oe({c_oe, b_oe, a_oe}),
    .board_lvl({brd_c, brd_b, brd_a}), .pin_lvl({c_in, b_in, a_in}));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Ends when pready reads high; only the bench timeout ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] port_rd(input logic [PORT_W-1:0] dv,
                                          input logic [PORT_W-1:0] dr,
                                          input logic [PORT_W-1:0] pv);
    // Outputs read back the latch, inputs read the pin
    return {24'h0, (dv & dr) | (pv & ~dr)};
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  // Toggle one port A line, expect a status pattern, then clear it
  task automatic evt(input int idx, input logic lvl,
                     input logic [ST_W-1:0] e);
    brd_a <= lvl ? (brd_a | (8'h1 << idx)) : (brd_a & ~(8'h1 << idx));
    wt(4);
    chk("irq", {31'h0, |(e & msk)}, {31'h0, irq});
    rd(A_STATUS, {23'h0, e}, "status");
    wr(A_STATUS, 32'h1ff);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    main_irq_pin_n = 1'b1;
    {brd_a, brd_b, brd_c} = '1;
    spi_pins = '0;
    msk = '0;
    sys_rst = 1'b1;
    void'($urandom(83));
    wt(3);
    sys_rst <= 1'b0;
    chk("oe", 32'h0, {8'h0, a_oe, b_oe, c_oe});
    chk("spi_in", 32'h8, {28'h0, spi_in});
    rd(A_DIR_A, 32'h0, "dir_a");
    rd(A_DIR_C, 32'h0, "dir_c");
    rd(A_OPTION, 32'h0, "option");
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rdat);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      m = (i == 0) ? 8'hff : 8'($urandom);
      brd_b <= 8'($urandom);
      wr(A_DIR_B, {24'h0, m});
      wr(A_DATA_B, {24'h0, d});
      wt(4);
      chk("b_oe", {24'h0, m}, {24'h0, b_oe});
      chk("b_out", {24'h0, d}, {24'h0, b_out});
      rd(A_DATA_B, port_rd(d, m, brd_b), "b_data");
    end
    // Port A driven by the device still feeds its interrupt sources
    wr(A_DATA_A, 32'hff);
    wr(A_DIR_A, 32'hff);
    wr(A_DATA_A, 32'h0);
    wt(4);
    chk("a_oe", 32'hff, {24'h0, a_oe});
    chk("a_out", 32'h0, {24'h0, a_out});
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(A_STATUS, 32'h1fe, "a_driven");
    wr(A_DATA_A, 32'hff);
    wr(A_DIR_A, 32'h0);
    // Serial unit owns C0..C3: drives C0 and C2, listens on C1, C3
    wr(A_DIR_C, 32'hff);
    wr(A_DATA_C, 32'h0);
    brd_c <= 8'h03;
    spi_pins <= {4'ha, 4'h5};
    wr(A_ALT, 32'h1 << ALT_SPI);
    // One edge for the drive, three for the pin to come back in
    wt(5);
    chk("c_oe", 32'hf5, {24'h0, c_oe});
    chk("c_out", 32'h0a, {24'h0, c_out});
    chk("spi_in", 32'h2, {28'h0, spi_in});
    wr(A_ALT, 32'h0);
    wt(4);
    chk("spi_in", 32'h8, {28'h0, spi_in});
    chk("c_oe", 32'hff, {24'h0, c_oe});
    brd_c <= 8'h80;
    wr(A_ALT, 32'h1e);
    wt(5);
    chk("c_oe", 32'h0f, {24'h0, c_oe});
    chk("caps", 32'h2, {30'h0, cap2, cap1});
    brd_c <= 8'h40;
    wt(4);
    chk("caps", 32'h1, {30'h0, cap2, cap1});
    wr(A_ALT, 32'h0);
    wt(4);
    chk("caps", 32'h0, {30'h0, cap2, cap1});
    msk = 9'h1ff;
    wr(A_MASK, {23'h0, msk});
    wr(A_STATUS, 32'h1ff);
    for (int i = 0; i < 2; i++) begin
      evt(LA_X1 + i, 1'b0, 9'h1 << (ST_X1 + i));
      evt(LA_X1 + i, 1'b1, 9'h0);
    end
    evt(LA_X3, 1'b0, 9'h1 << ST_X3);
    evt(LA_X3, 1'b1, 9'h1 << ST_X3);
    for (int k = 0; k < KB_N; k++) begin
      evt(LA_KB + k, 1'b0, 9'h1 << (ST_KB + k));
      evt(LA_KB + k, 1'b1, 9'h0);
    end
    // Masked source still latches status but keeps irq low
    msk = 9'h1fd;
    wr(A_MASK, {23'h0, msk});
    evt(LA_X1, 1'b0, 9'h1 << ST_X1);
    evt(LA_X1, 1'b1, 9'h0);
    main_irq_pin_n <= 1'b0;
    wt(4);
    wr(A_STATUS, 32'h1ff);
    wt(2);
    rd(A_STATUS, 32'h1, "main_level");
    main_irq_pin_n <= 1'b1;
    wt(4);
    wr(A_STATUS, 32'h1ff);
    wr(A_OPTION, 32'h1 << OPT_EDGE);
    wr(A_OPTION, 32'h0);
    rd(A_OPTION, 32'h1, "option");
    main_irq_pin_n <= 1'b0;
    wt(4);
    rd(A_STATUS, 32'h1, "main_fall");
    wr(A_STATUS, 32'h1ff);
    wt(4);
    rd(A_STATUS, 32'h0, "main_edge");
    main_irq_pin_n <= 1'b1;
    apb(1'b1, 8'h3c, 32'hffff);
    chk("unmapped", 32'h1, {31'h0, err});
    sys_rst <= 1'b1;
    wt(2);
    sys_rst <= 1'b0;
    chk("oe", 32'h0, {8'h0, a_oe, b_oe, c_oe});
    rd(A_DIR_B, 32'h0, "dir_b");
    rd(A_OPTION, 32'h0, "option");
    test_done();
  end
endmodule
`default_nettype wire
